// ---- tts_pkg.sv ----
// Package: register map, field masks and reset values of the threshold block
package tts_pkg;

    localparam int          NUM_CH             = 5;

    // Register offsets
    localparam logic [7:0]  PRI_HI_FLAGS_OFS   = 8'h0c;
    localparam logic [7:0]  PRI_LO_FLAGS_OFS   = 8'h0d;
    localparam logic [7:0]  PRI_OVER_LIM_OFS   = 8'h1d;
    localparam logic [7:0]  PRI_OVER_LIM_LAST  = 8'h26;
    localparam logic [7:0]  PRI_UNDER_MSB_OFS  = 8'h27;
    localparam logic [7:0]  PRI_UNDER_LSB_OFS  = 8'h28;
    localparam logic [7:0]  SEC_OVER_LIM_OFS   = 8'h29;
    localparam logic [7:0]  SEC_OVER_LIM_LAST  = 8'h2d;
    localparam logic [7:0]  SEC_UNDER_LIM_OFS  = 8'h2e;
    localparam logic [7:0]  SEC_HI_FLAGS_OFS   = 8'h42;
    localparam logic [7:0]  SEC_LO_FLAGS_OFS   = 8'h43;

    // Field layout
    localparam logic [7:0]  FRAC_MASK          = 8'hf0;
    localparam logic [2:0]  FLAG_RSVD          = 3'h0;
    localparam logic [7:0]  INT_ALIGN          = 8'h00;
    localparam logic [7:0]  UNMAPPED_DATA      = 8'h00;

    // Reset values
    localparam logic [15:0] PRI_OVER_LIM_RST   = 16'h7f00;
    localparam logic [15:0] PRI_UNDER_LIM_RST  = 16'h8000;
    localparam logic [7:0]  SEC_OVER_LIM_RST   = 8'h7f;
    localparam logic [7:0]  SEC_UNDER_LIM_RST  = 8'h80;
    localparam logic [4:0]  FLAGS_RST          = 5'h00;
    localparam logic [7:0]  RDATA_RST          = 8'h00;

endpackage

// ---- tts_top.sv ----
// Thermal limit registers, status flags and alarm outputs of a five-channel
// temperature monitor
//
// Functional notes
// - Primary under LSB keeps only fraction bits
// - Stored limits never converted on format change
// - Shared secondary under limit drives secondary alarm
// - Secondary under limit is one signed byte
// - Primary high flag when above own limit
// - Primary low flag when below shared limit
// - Secondary high flag when above own limit
// - Secondary low flag when below shared limit
// - Reading a status register clears its flags
// - Bit 0 local, bits 1-4 remote, rest zero
// - Primary under MSB holds sign and integer
// - Primary over fault asserts primary alarm
// - Primary under fault asserts primary alarm
// - Secondary over fault asserts secondary alarm
module tts_top
    import tts_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    // Register access from the serial interface
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Conversion results
    input  wire logic        conv_done_i,
    input  wire logic [2:0]  conv_chan_i,
    input  wire logic [15:0] conv_temp_i,
    // Alarm masks
    input  wire logic [4:0]  pri_alarm_mask_i,
    input  wire logic [4:0]  sec_alarm_mask_i,
    // Open-drain alarm pins
    output logic             primary_alarm_n_o,
    output logic             primary_alarm_oe_o,
    output logic             secondary_alarm_n_o,
    output logic             secondary_alarm_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [15:0] pri_over_lim_reg [NUM_CH];
    logic [7:0]  sec_over_lim_reg [NUM_CH];
    logic [15:0] pri_under_lim_reg;
    logic [7:0]  sec_under_lim_reg;
    logic [4:0]  pri_hi_reg;
    logic [4:0]  pri_lo_reg;
    logic [4:0]  sec_hi_reg;
    logic [4:0]  sec_lo_reg;
    logic [7:0]  rdata_reg;
    logic        pri_alarm_n_reg;
    logic        sec_alarm_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire         wr_en       = ce_i & reg_wr_i;
    wire         rd_en       = ce_i & reg_rd_i;
    wire  [7:0]  po_rel      = reg_addr_i - PRI_OVER_LIM_OFS;
    wire  [7:0]  so_rel      = reg_addr_i - SEC_OVER_LIM_OFS;
    wire  [2:0]  po_idx      = po_rel[3:1];
    wire  [2:0]  so_idx      = so_rel[2:0];
    wire         po_lsb      = po_rel[0];
    wire         po_hit      = (reg_addr_i >= PRI_OVER_LIM_OFS) &&
                               (reg_addr_i <= PRI_OVER_LIM_LAST);
    wire         so_hit      = (reg_addr_i >= SEC_OVER_LIM_OFS) &&
                               (reg_addr_i <= SEC_OVER_LIM_LAST);
    wire         pu_msb_hit  = reg_addr_i == PRI_UNDER_MSB_OFS;
    wire         pu_lsb_hit  = reg_addr_i == PRI_UNDER_LSB_OFS;
    wire         su_hit      = reg_addr_i == SEC_UNDER_LIM_OFS;
    wire         pri_hi_clr  = rd_en && (reg_addr_i == PRI_HI_FLAGS_OFS);
    wire         pri_lo_clr  = rd_en && (reg_addr_i == PRI_LO_FLAGS_OFS);
    wire         sec_hi_clr  = rd_en && (reg_addr_i == SEC_HI_FLAGS_OFS);
    wire         sec_lo_clr  = rd_en && (reg_addr_i == SEC_LO_FLAGS_OFS);

    ////////////////////////////////////////////////////////////////////////
    // Limit registers
    // stored as written, LSB bytes masked to fraction bits
    // Values are kept once stored; the format bit elsewhere never rewrites
    // them, so software must reprogram limits after switching format.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                pri_over_lim_reg[i] <= PRI_OVER_LIM_RST;
                sec_over_lim_reg[i] <= SEC_OVER_LIM_RST;
            end
            pri_under_lim_reg <= PRI_UNDER_LIM_RST;
            sec_under_lim_reg <= SEC_UNDER_LIM_RST;
        end else if (wr_en) begin
            if (po_hit && po_lsb)
                pri_over_lim_reg[po_idx][7:0] <= reg_wdata_i & FRAC_MASK;
            if (po_hit && !po_lsb)
                pri_over_lim_reg[po_idx][15:8] <= reg_wdata_i;
            if (so_hit)
                sec_over_lim_reg[so_idx] <= reg_wdata_i;
            if (pu_msb_hit)
                pri_under_lim_reg[15:8] <= reg_wdata_i;
            if (pu_lsb_hit)
                pri_under_lim_reg[7:0] <= reg_wdata_i & FRAC_MASK;
            if (su_hit)
                sec_under_lim_reg <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel comparison
    logic [4:0] pri_hi_set;
    logic [4:0] pri_lo_set;
    logic [4:0] sec_hi_set;
    logic [4:0] sec_lo_set;
    wire signed [15:0] temp_s   = conv_temp_i;
    wire signed [15:0] pu_lim_s = pri_under_lim_reg;
    wire signed [15:0] su_lim_s = {sec_under_lim_reg, INT_ALIGN};

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        wire               sel      = ce_i & conv_done_i &
                                      (conv_chan_i == 3'(c));
        wire signed [15:0] po_lim_s = pri_over_lim_reg[c];
        wire signed [15:0] so_lim_s = {sec_over_lim_reg[c], INT_ALIGN};
        assign pri_hi_set[c] = sel & (temp_s > po_lim_s);
        assign pri_lo_set[c] = sel & (temp_s < pu_lim_s);
        assign sec_hi_set[c] = sel & (temp_s > so_lim_s);
        assign sec_lo_set[c] = sel & (temp_s < su_lim_s);
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags
    // clear on read
    // A fault seen in the very cycle of the read survives it.
    wire [4:0] pri_hi_next = (pri_hi_reg & ~{5{pri_hi_clr}}) | pri_hi_set;
    wire [4:0] pri_lo_next = (pri_lo_reg & ~{5{pri_lo_clr}}) | pri_lo_set;
    wire [4:0] sec_hi_next = (sec_hi_reg & ~{5{sec_hi_clr}}) | sec_hi_set;
    wire [4:0] sec_lo_next = (sec_lo_reg & ~{5{sec_lo_clr}}) | sec_lo_set;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pri_hi_reg <= FLAGS_RST;
            pri_lo_reg <= FLAGS_RST;
            sec_hi_reg <= FLAGS_RST;
            sec_lo_reg <= FLAGS_RST;
        end else if (ce_i) begin
            pri_hi_reg <= pri_hi_next;
            pri_lo_reg <= pri_lo_next;
            sec_hi_reg <= sec_hi_next;
            sec_lo_reg <= sec_lo_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarms follow the unmasked flags
    // primary and secondary alarms, over or under
    wire pri_alarm = |((pri_hi_next | pri_lo_next) & ~pri_alarm_mask_i);
    wire sec_alarm = |((sec_hi_next | sec_lo_next) & ~sec_alarm_mask_i);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pri_alarm_n_reg <= 1'b1;
            sec_alarm_n_reg <= 1'b1;
        end else if (ce_i) begin
            pri_alarm_n_reg <= ~pri_alarm;
            sec_alarm_n_reg <= ~sec_alarm;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data
    // channel bit layout
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = UNMAPPED_DATA;
        if (reg_addr_i == PRI_HI_FLAGS_OFS)
            rd_mux = {FLAG_RSVD, pri_hi_reg};
        else if (reg_addr_i == PRI_LO_FLAGS_OFS)
            rd_mux = {FLAG_RSVD, pri_lo_reg};
        else if (reg_addr_i == SEC_HI_FLAGS_OFS)
            rd_mux = {FLAG_RSVD, sec_hi_reg};
        else if (reg_addr_i == SEC_LO_FLAGS_OFS)
            rd_mux = {FLAG_RSVD, sec_lo_reg};
        else if (po_hit && po_lsb)
            rd_mux = pri_over_lim_reg[po_idx][7:0];
        else if (po_hit)
            rd_mux = pri_over_lim_reg[po_idx][15:8];
        else if (so_hit)
            rd_mux = sec_over_lim_reg[so_idx];
        else if (pu_msb_hit)
            rd_mux = pri_under_lim_reg[15:8];
        else if (pu_lsb_hit)
            rd_mux = pri_under_lim_reg[7:0];
        else if (su_hit)
            rd_mux = sec_under_lim_reg;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i)
            rdata_reg <= RDATA_RST;
        else if (rd_en)
            rdata_reg <= rd_mux;
    end

    assign reg_rdata_o          = rdata_reg;
    assign primary_alarm_n_o    = pri_alarm_n_reg;
    assign primary_alarm_oe_o   = ~pri_alarm_n_reg;
    assign secondary_alarm_n_o  = sec_alarm_n_reg;
    assign secondary_alarm_oe_o = ~sec_alarm_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence read_pri_hi_s;
        pri_hi_clr && (pri_hi_set == 5'h00);
    endsequence

    sequence read_flag_s;
        rd_en && ((reg_addr_i == PRI_HI_FLAGS_OFS) ||
                  (reg_addr_i == PRI_LO_FLAGS_OFS) ||
                  (reg_addr_i == SEC_HI_FLAGS_OFS) ||
                  (reg_addr_i == SEC_LO_FLAGS_OFS));
    endsequence

    under_frac_zero_a: assert property (
        pri_under_lim_reg[3:0] == 4'h0)
        else $error("primary under limit low nibble not zero");

    limit_hold_a: assert property (
        !wr_en |=> $stable(pri_under_lim_reg) && $stable(sec_under_lim_reg))
        else $error("limit changed without a write");

    sec_lim_store_a: assert property (
        wr_en && su_hit |=> sec_under_lim_reg == $past(reg_wdata_i))
        else $error("secondary under limit not stored");

    under_msb_store_a: assert property (
        wr_en && pu_msb_hit |=> pri_under_lim_reg[15:8] == $past(reg_wdata_i))
        else $error("primary under limit msb not stored");

    pri_hi_flag_a: assert property (
        (|pri_hi_set) |=> (pri_hi_reg & $past(pri_hi_set)) == $past(pri_hi_set))
        else $error("primary high flag not set");

    pri_lo_flag_a: assert property (
        (|pri_lo_set) |=> (pri_lo_reg & $past(pri_lo_set)) == $past(pri_lo_set))
        else $error("primary low flag not set");

    sec_hi_flag_a: assert property (
        (|sec_hi_set) |=> (sec_hi_reg & $past(sec_hi_set)) == $past(sec_hi_set))
        else $error("secondary high flag not set");

    sec_lo_flag_a: assert property (
        ce_i && conv_done_i && (conv_chan_i == 3'h1) && (temp_s < su_lim_s)
        |=> sec_lo_reg[1])
        else $error("secondary low flag not set");

    read_clear_a: assert property (
        read_pri_hi_s |=> pri_hi_reg == 5'h00)
        else $error("primary high flags not cleared by read");

    rsvd_zero_a: assert property (
        read_flag_s |=> reg_rdata_o[7:5] == 3'h0)
        else $error("reserved status bits not zero");

    pri_alarm_a: assert property (
        ce_i && |(pri_hi_set & ~pri_alarm_mask_i) |=> !primary_alarm_n_o)
        else $error("primary alarm missing on over fault");

    pri_under_alarm_a: assert property (
        ce_i && |(pri_lo_set & ~pri_alarm_mask_i) |=> !primary_alarm_n_o)
        else $error("primary alarm missing on under fault");

    sec_under_alarm_a: assert property (
        ce_i && |(sec_lo_set & ~sec_alarm_mask_i) |=> !secondary_alarm_n_o)
        else $error("secondary alarm missing on under fault");

    sec_over_alarm_a: assert property (
        ce_i && |(sec_hi_set & ~sec_alarm_mask_i) |=> !secondary_alarm_n_o)
        else $error("secondary alarm missing on over fault");

    int_align_a: assert property (
        ce_i && conv_done_i && (conv_chan_i == 3'h4) &&
        ($signed(conv_temp_i[15:8]) > $signed(sec_over_lim_reg[4]))
        |-> sec_hi_set[4])
        else $error("secondary over compare not integer aligned");

    equal_no_fault_a: assert property (
        (temp_s == pu_lim_s) |-> (pri_lo_set == 5'h00))
        else $error("equality raised an under fault");

endmodule

// ---- tts_host_model.sv ----
// Host model: byte writes and clearing reads on the register access port
module tts_host_model (
    // Clock
    input  wire logic       clk_i,
    // Register access
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // limits sent ready-formatted
    // The device never converts stored bytes, so the host owns the format
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = 1'b1;
        @(negedge clk_i);
        reg_wr_o    = 1'b0;
        // Released lines show no stale value
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask

    // Read data is sampled half a cycle after the strobe is taken
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_i);
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(negedge clk_i);
        data       = reg_rdata_i;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~addr;
    endtask
endmodule

// ---- test_thermal_threshold_status.sv ----
// Testbench: limit registers, status flags and alarm pins
module test_thermal_threshold_status;
    import tts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        srst;
    logic        ce;
    logic        conv_done;
    logic [2:0]  conv_chan;
    logic [15:0] conv_temp;
    logic [4:0]  pri_mask;
    logic [4:0]  sec_mask;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        p_n;
    logic        p_oe;
    logic        s_n;
    logic        s_oe;
    int          miscompares = 0;
    int          check_count = 0;

    tts_top dut_u (
        .clk_i               (clk),
        .srst_i              (srst),
        .ce_i                (ce),
        .reg_addr_i          (addr),
        .reg_wdata_i         (wdata),
        .reg_wr_i            (wr),
        .reg_rd_i            (rd),
        .reg_rdata_o         (rdata),
        .conv_done_i         (conv_done),
        .conv_chan_i         (conv_chan),
        .conv_temp_i         (conv_temp),
        .pri_alarm_mask_i    (pri_mask),
        .sec_alarm_mask_i    (sec_mask),
        .primary_alarm_n_o   (p_n),
        .primary_alarm_oe_o  (p_oe),
        .secondary_alarm_n_o (s_n),
        .secondary_alarm_oe_o(s_oe)
    );

    tts_host_model u_host (
        .clk_i      (clk),
        .reg_addr_o (addr),
        .reg_wdata_o(wdata),
        .reg_wr_o   (wr),
        .reg_rd_o   (rd),
        .reg_rdata_i(rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        u_host.write_reg(a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.read_reg(a, d);
        check($sformatf("reg %h", a), d, e);
    endtask

    // Open-drain pins: enable high exactly while the level is low
    task automatic pins(input logic p, input logic s);
        check("primary alarm", {6'h00, p_oe, p_n}, {6'h00, p, ~p});
        check("secondary alarm", {6'h00, s_oe, s_n}, {6'h00, s, ~s});
    endtask

    task automatic conv(input logic [2:0] ch, input logic [15:0] t);
        @(negedge clk);
        conv_chan = ch;
        conv_temp = t;
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
        conv_temp = ~t;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        srst      = 1'b1;
        ce        = 1'b1;
        conv_done = 1'b0;
        conv_chan = 3'h0;
        conv_temp = 16'h0000;
        pri_mask  = 5'h00;
        sec_mask  = 5'h00;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        rc(PRI_HI_FLAGS_OFS, 8'h00);
        rc(PRI_LO_FLAGS_OFS, 8'h00);
        rc(SEC_HI_FLAGS_OFS, 8'h00);
        rc(SEC_LO_FLAGS_OFS, 8'h00);
        rc(SEC_UNDER_LIM_OFS, SEC_UNDER_LIM_RST);
        rc(PRI_UNDER_MSB_OFS, PRI_UNDER_LIM_RST[15:8]);
        rc(8'h50, UNMAPPED_DATA);
        pins(1'b0, 1'b0);
        wr_b(PRI_UNDER_LSB_OFS, 8'hff);
        rc(PRI_UNDER_LSB_OFS, 8'hf0);
        wr_b(PRI_UNDER_MSB_OFS, 8'hf6);
        wr_b(PRI_UNDER_LSB_OFS, 8'h00);
        rc(PRI_UNDER_MSB_OFS, 8'hf6);
        // Primary over limit of channel 2 is 50.3125 degrees
        wr_b(8'h21, 8'h32);
        wr_b(8'h22, 8'h50);
        rc(8'h22, 8'h50);
        wr_b(PRI_HI_FLAGS_OFS, 8'hff);
        conv(3'h2, 16'h3250);
        rc(PRI_HI_FLAGS_OFS, 8'h00);
        conv(3'h2, 16'h3260);
        pins(1'b1, 1'b0);
        rc(PRI_HI_FLAGS_OFS, 8'h04);
        rc(PRI_HI_FLAGS_OFS, 8'h00);
        pins(1'b0, 1'b0);
        conv(3'h2, 16'h3260);
        rc(PRI_HI_FLAGS_OFS, 8'h04);
        conv(3'h5, 16'h7ff0);
        rc(PRI_HI_FLAGS_OFS, 8'h00);
        // Shared primary under limit is -10 degrees
        pri_mask = 5'h01;
        conv(3'h0, 16'hf600);
        rc(PRI_LO_FLAGS_OFS, 8'h00);
        conv(3'h0, 16'hf5f0);
        pins(1'b0, 1'b0);
        rc(PRI_LO_FLAGS_OFS, 8'h01);
        pri_mask = 5'h00;
        conv(3'h3, 16'hf5f0);
        pins(1'b1, 1'b0);
        rc(PRI_LO_FLAGS_OFS, 8'h08);
        // One-byte secondary over limit of channel 4 is 30 degrees
        wr_b(8'h2d, 8'h1e);
        rc(8'h2d, 8'h1e);
        conv(3'h4, 16'h1e00);
        rc(SEC_HI_FLAGS_OFS, 8'h00);
        conv(3'h4, 16'h1e10);
        pins(1'b0, 1'b1);
        rc(SEC_HI_FLAGS_OFS, 8'h10);
        sec_mask = 5'h10;
        // Integer part above the byte limit
        conv(3'h4, 16'h1f00);
        pins(1'b0, 1'b0);
        rc(SEC_HI_FLAGS_OFS, 8'h10);
        sec_mask = 5'h00;
        // Shared secondary under limit is -20 degrees
        wr_b(PRI_UNDER_MSB_OFS, 8'h80);
        wr_b(SEC_UNDER_LIM_OFS, 8'hec);
        rc(SEC_UNDER_LIM_OFS, 8'hec);
        conv(3'h1, 16'hec00);
        rc(SEC_LO_FLAGS_OFS, 8'h00);
        conv(3'h1, 16'hebf0);
        pins(1'b0, 1'b1);
        rc(SEC_LO_FLAGS_OFS, 8'h02);
        wr_b(SEC_UNDER_LIM_OFS, 8'h80);
        conv(3'h1, 16'hebf0);
        rc(SEC_LO_FLAGS_OFS, 8'h00);
        pins(1'b0, 1'b0);
        // Clock enable low freezes limits and flags
        ce = 1'b0;
        wr_b(SEC_UNDER_LIM_OFS, 8'h11);
        conv(3'h2, 16'h3260);
        ce = 1'b1;
        rc(SEC_UNDER_LIM_OFS, 8'h80);
        rc(PRI_HI_FLAGS_OFS, 8'h00);
        pins(1'b0, 1'b0);
        results();
    end
endmodule
